// ---- backplane_storage_transceiver.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - One 8-bit and one 9-bit group, seventeen two-way channels.
// R2 - Backplane drivers on only when true enable high, inverted enable low.
// R3 - Logic outputs show inverted backplane data while logic enable high.
// R4 - Logic outputs float while logic enable is low.
// R5 - Both enables active drive both directions at the same time.
// R6 - Pass enable high is transparent; low stores on rising capture clock.
// R7 - Each direction has its own store, pass enable and capture clock.
module backplane_storage_transceiver
   import xcvr_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_logic_side_output_enable,
   input wire logic i_backplane_output_enable,
   input wire logic i_backplane_output_enable_n,
   input wire logic i_pass_enable_to_backplane,
   input wire logic i_capture_clock_to_backplane,
   input wire logic i_pass_enable_to_logic_side,
   input wire logic i_capture_clock_to_logic_side,
   input wire logic [CHAN_W-1:0] i_logic_in,
   input wire logic [CHAN_W-1:0] i_backplane_in,
   output logic [CHAN_W-1:0] o_logic_out,
   output logic [CHAN_W-1:0] o_logic_oe,
   output logic [CHAN_W-1:0] o_backplane_out,
   output logic [CHAN_W-1:0] o_backplane_oe,
   output logic o_fifo_ready
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   // The capture clocks are sampled like any other pin, so a rising edge
   // is a low sample followed by a high one on two enabled cycles.
   typedef struct packed {
      logic clk_ab;
      logic clk_ba;
      logic [CHAN_W-1:0] store_ab;
      logic [CHAN_W-1:0] store_ba;
      logic [CHAN_W-1:0] lout;
      logic [CHAN_W-1:0] loe;
      logic [CHAN_W-1:0] bout;
      logic [CHAN_W-1:0] boe;
      logic fready;
   } xcvr_s;
   xcvr_s q, d;
   // ------------------------------------------------------------
   // Receive buffer
   // ------------------------------------------------------------
   xcvr_stream_if #(.W(CHAN_W)) fin ();
   xcvr_stream_if #(.W(CHAN_W)) fout ();
   // Backplane-to-logic data passes the FIFO before the logic-side store;
   // its output is always ready, so it never fills and o_fifo_ready stays high.
   assign fin.valid = 1'b1;
   assign fin.data = i_backplane_in;
   assign fout.ready = 1'b1;
   xcvr_fifo #(.W(CHAN_W), .DEPTH(DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .in_s(fin),
      .out_s(fout)
   );
   logic [CHAN_W-1:0] ab_val, ba_val, ba_in;
   logic rise_ab, rise_ba, b_on;
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      // Until the buffer yields its first word the logic-side store keeps
      // its own value instead of taking an undefined one.
      ba_in = fout.valid ? fout.data : q.store_ba;
      d.clk_ab = i_capture_clock_to_backplane;
      d.clk_ba = i_capture_clock_to_logic_side;
      rise_ab = i_capture_clock_to_backplane && !q.clk_ab;
      rise_ba = i_capture_clock_to_logic_side && !q.clk_ba;
      // Separate stores per direction. [R7]
      if (i_pass_enable_to_backplane || rise_ab) begin
         d.store_ab = i_logic_in; // [R6]
      end
      if (i_pass_enable_to_logic_side || rise_ba) begin
         d.store_ba = ba_in; // [R6]
      end
      // The inversion sits after the store, so a captured word leaves
      // inverted exactly like a passed one.
      ab_val = d.store_ab;
      ba_val = d.store_ba;
      // Either a low true enable or a high inverted enable isolates the
      // backplane; both must agree before any line is pulled.
      b_on = i_backplane_output_enable && !i_backplane_output_enable_n;
      // Both directions evaluated independently, so both may drive. [R5]
      d.bout = ~ab_val; // [R1]
      d.boe = {CHAN_W{b_on}}; // [R2]
      d.lout = ~ba_val; // [R3]
      d.loe = {CHAN_W{i_logic_side_output_enable}}; // [R4]
      d.fready = fin.ready;
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Everything clears to zero, the stores through STORE_RESET, so both sides come out of
   // reset undriven.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
         q.store_ab <= STORE_RESET;
         q.store_ba <= STORE_RESET;
      end else if (i_ce) begin
         q <= d;
      end
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_logic_out = q.lout;
   assign o_logic_oe = q.loe;
   assign o_backplane_out = q.bout;
   assign o_backplane_oe = q.boe;
   assign o_fifo_ready = q.fready;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Every output is registered, so each check looks one cycle ahead; a
   // frozen cycle must leave every output where it was.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   // The backplane is driven only in one of its four enable codes.
   sequence s_bp_on;
      i_backplane_output_enable && !i_backplane_output_enable_n;
   endsequence
   sequence s_bp_off;
      !i_backplane_output_enable || i_backplane_output_enable_n;
   endsequence
   // A capture edge counts only while the pass enable of that direction
   // is low; otherwise the path is transparent anyway.
   sequence s_ab_edge;
      i_ce && !i_pass_enable_to_backplane &&
      i_capture_clock_to_backplane && !q.clk_ab;
   endsequence
   sequence s_ba_edge;
      i_ce && !i_pass_enable_to_logic_side &&
      i_capture_clock_to_logic_side && !q.clk_ba;
   endsequence
   // Quiet means an enabled cycle with neither passing nor capturing.
   sequence s_ab_quiet;
      i_ce && !i_pass_enable_to_backplane &&
      !(i_capture_clock_to_backplane && !q.clk_ab);
   endsequence
   sequence s_ba_quiet;
      i_ce && !i_pass_enable_to_logic_side &&
      !(i_capture_clock_to_logic_side && !q.clk_ba);
   endsequence
   // ------------------------------------------------------------
   // Enable checks
   // ------------------------------------------------------------
   a_boe_gating: assert property (i_ce |=> o_backplane_oe == // [R2]
      {CHAN_W{$past(i_backplane_output_enable) &&
      !$past(i_backplane_output_enable_n)}})
      else $error("backplane enable gating wrong");
   a_boe_off: assert property ( // [R2]
      i_ce ##0 s_bp_off |=> o_backplane_oe == '0)
      else $error("backplane not released");
   a_loe_float: assert property (i_ce && !i_logic_side_output_enable // [R4]
      |=> o_logic_oe == '0) else $error("logic side not floated");
   a_loe_drive: assert property (i_ce && i_logic_side_output_enable // [R3]
      |=> o_logic_oe == '1) else $error("logic side not driven");
   a_both_drive: assert property ( // [R5]
      (i_ce && i_logic_side_output_enable) ##0 s_bp_on
      |=> o_logic_oe == '1 && o_backplane_oe == '1)
      else $error("both sides not driven");
   // ------------------------------------------------------------
   // Storage checks
   // ------------------------------------------------------------
   // Each direction is checked on its own, since the two stores share
   // neither pass enable nor capture clock.
   a_ab_transp: assert property (i_ce && i_pass_enable_to_backplane // [R6]
      |=> o_backplane_out == ~$past(i_logic_in))
      else $error("transparent path wrong");
   a_low_group: assert property ( // [R1]
      i_ce && i_pass_enable_to_backplane |=>
      o_backplane_out[LOW_GROUP_W-1:0] ==
      ~$past(i_logic_in[LOW_GROUP_W-1:0]))
      else $error("lower channel group wrong");
   a_high_group: assert property ( // [R1]
      i_ce && i_pass_enable_to_backplane |=>
      o_backplane_out[CHAN_W-1:LOW_GROUP_W] ==
      ~$past(i_logic_in[CHAN_W-1:LOW_GROUP_W]))
      else $error("upper channel group wrong");
   a_ab_capture: assert property (s_ab_edge |=> // [R6]
      o_backplane_out == ~$past(i_logic_in))
      else $error("backplane capture wrong");
   a_ab_hold: assert property (s_ab_quiet |=> $stable(q.store_ab)) // [R7]
      else $error("store not held");
   a_ba_invert: assert property ( // [R3]
      i_ce && i_pass_enable_to_logic_side && fout.valid
      |=> o_logic_out == ~$past(fout.data))
      else $error("logic side not inverted");
   a_ba_capture: assert property (s_ba_edge ##0 fout.valid |=> // [R6]
      o_logic_out == ~$past(fout.data))
      else $error("logic side capture wrong");
   a_ba_hold: assert property (s_ba_quiet |=> $stable(q.store_ba)) // [R7]
      else $error("logic side store not held");
   a_ce_freeze: assert property (!i_ce |=> // [R6]
      $stable(o_backplane_out) && $stable(o_logic_out) &&
      $stable(o_backplane_oe) && $stable(o_logic_oe))
      else $error("outputs moved while frozen");
   // ------------------------------------------------------------
   // Receive path checks
   // ------------------------------------------------------------
   // The buffer is drained every cycle it is filled, so it never fills.
   a_fifo_ready: assert property (i_ce |=> o_fifo_ready) // [R3]
      else $error("receive buffer filled up");
endmodule // backplane_storage_transceiver
`default_nettype wire

// ---- xcvr_pkg.sv ----
package xcvr_pkg;
   localparam int LOW_GROUP_W = 8;
   localparam int HIGH_GROUP_W = 9;
   localparam int CHAN_W = LOW_GROUP_W + HIGH_GROUP_W;
   localparam int FIFO_DEPTH = 16;
   localparam logic [CHAN_W-1:0] STORE_RESET = 17'h00000;
endpackage

// ---- xcvr_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface xcvr_stream_if #(parameter int W = 17);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- xcvr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module xcvr_fifo #(
   parameter int W = 17,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   xcvr_stream_if.snk in_s,
   xcvr_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [W-1:0] rdata;
      logic rvalid;
   } fifo_s;
   fifo_s q, d;
   logic [W-1:0] mem [DEPTH];
   logic full, empty, push, pop;
   always_comb begin
      full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
      empty = (q.wp == q.rp);
      push = in_s.valid && !full;
      pop = !empty && (!q.rvalid || out_s.ready);
      d = q;
      if (push) begin
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
         d.rdata = mem[q.rp[AW-1:0]];
         d.rvalid = 1'b1;
      end else if (out_s.ready) begin
         d.rvalid = 1'b0;
      end
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
         if (push) begin
            mem[q.wp[AW-1:0]] <= in_s.data;
         end
      end
   end
   assign in_s.ready = !full;
   assign out_s.valid = q.rvalid;
   assign out_s.data = q.rdata;
endmodule // xcvr_fifo
`default_nettype wire

// ---- bp_card_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Another card on the shared open-drain backplane; a released line is
// pulled up, so the wire is low when either party pulls it low.
module bp_card_model
   import xcvr_pkg::*;
(
   input wire logic [CHAN_W-1:0] i_card_low,
   input wire logic [CHAN_W-1:0] i_dut_out,
   input wire logic [CHAN_W-1:0] i_dut_oe,
   output logic [CHAN_W-1:0] o_wire
);
   assign o_wire = ~i_card_low & ~(i_dut_oe & ~i_dut_out);
endmodule // bp_card_model
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import xcvr_pkg::*;
;
   logic clk = 0, rst = 1, logic_side_output_enable = 0, backplane_output_enable = 0, oeb_n = 1;
   logic pab = 1, cab = 0, pba = 1, cba = 0, rdy, ce = 1;
   logic [CHAN_W-1:0] lin = '0, card = '0, bw, lout, loe, bout, boe, keep;
   int num_errors = 0, n_tests = 0, cyc = 0;
   always #4 clk = ~clk;
   backplane_storage_transceiver dut (.i_clk(clk), .i_rst(rst),
      .i_ce(ce), .i_logic_side_output_enable(logic_side_output_enable),
      .i_backplane_output_enable(backplane_output_enable),
      .i_backplane_output_enable_n(oeb_n),
      .i_pass_enable_to_backplane(pab),
      .i_capture_clock_to_backplane(cab),
      .i_pass_enable_to_logic_side(pba),
      .i_capture_clock_to_logic_side(cba), .i_logic_in(lin),
      .i_backplane_in(bw), .o_logic_out(lout), .o_logic_oe(loe),
      .o_backplane_out(bout), .o_backplane_oe(boe), .o_fifo_ready(rdy));
   bp_card_model card_m (.i_card_low(card), .i_dut_out(bout),
      .i_dut_oe(boe), .o_wire(bw));
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [CHAN_W-1:0] e, g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // The whole run needs well under a thousand cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'h833e));
      wt(8);
      rst <= 1'b0;
      // The first eight passes walk every enable combination.
      for (int i = 0; i < 40; i++) begin
         wt(1);
         {logic_side_output_enable, backplane_output_enable, oeb_n} <= (i < 8) ? i[2:0] : 3'($urandom);
         lin <= 17'($urandom);
         card <= 17'($urandom);
         wt(6);
         @(negedge clk);
         chk("boe", {CHAN_W{backplane_output_enable & ~oeb_n}}, boe);
         chk("loe", {CHAN_W{logic_side_output_enable}}, loe);
         chk("bout", ~lin, bout);
         if (logic_side_output_enable) chk("lout", ~bw, lout);
      end
      // A frozen clock enable must keep the last word on the backplane.
      keep = lin;
      ce <= 1'b0;
      lin <= 17'h00f0f;
      wt(4);
      @(negedge clk);
      chk("frozen", ~keep, bout);
      wt(1);
      ce <= 1'b1;
      wt(3);
      @(negedge clk);
      chk("thawed", ~17'h00f0f, bout);
      wt(1);
      {pab, pba, logic_side_output_enable, backplane_output_enable, oeb_n} <= 5'b00101;
      lin <= 17'h0a5a5;
      card <= 17'h13c3c;
      wt(8);
      {cab, cba} <= 2'b11;
      wt(3);
      {cab, cba} <= 2'b00;
      lin <= '1;
      card <= '0;
      // Long gap so the stream path has settled before capturing.
      wt(8);
      cba <= 1'b1;
      wt(8);
      @(negedge clk);
      chk("held", 17'h15a5a, bout);
      chk("cap", 17'h00000, lout);
      chk("rdy", 17'h00001, {16'h0000, rdy});
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
